// ===== design/gtu_pkg.sv
// constants, field layout and register map of the general timer unit
// assumes an apb master with 32-bit data and one clock domain
package gtu_pkg;

    // timer indices
    localparam int GTU_AUX_LOW = 0;
    localparam int GTU_CORE1 = 1;
    localparam int GTU_AUX_HIGH = 2;
    localparam int GTU_AUX2 = 3;
    localparam int GTU_CORE2 = 4;
    localparam int GTU_NTIM = 5;

    // apb byte addresses
    localparam logic [7:0] GTU_CTRL_BASE = 8'h00;
    localparam logic [7:0] GTU_CNT_BASE = 8'h14;
    localparam logic [7:0] GTU_CAPTURE_RELOAD_REGISTER_OFS = 8'h28;
    localparam logic [7:0] GTU_FLAGS_OFS = 8'h2c;
    localparam logic [7:0] GTU_STATUS_OFS = 8'h30;

    // control word fields
    localparam int GTU_PS_LSB = 0;
    localparam int GTU_MODE_LSB = 3;
    localparam int GTU_RUN = 5;
    localparam int GTU_DOWN = 6;
    localparam int GTU_EXTDIR = 7;
    localparam int GTU_EDGE_LSB = 8;
    localparam int GTU_GATE_LVL = 10;
    localparam int GTU_OUT_EN = 11;
    localparam int GTU_CHAIN = 14;
    // aux_low extra fields
    localparam int GTU_CR_EN = 12;
    localparam int GTU_CR_RELOAD = 13;
    localparam int GTU_REL_LATCH = 15;
    // core2 extra fields
    localparam int GTU_CAPTURE_RELOAD_REGISTER_REL = 12;
    localparam int GTU_CAPEDGE_LSB = 14;
    // aux2 extra fields
    localparam int GTU_CAP_CLR = 12;
    localparam int GTU_CAP_FIRST_CORE_COUNT_INPUT = 13;
    localparam int GTU_CAP_T3DIR = 15;

    // flag bits
    localparam int GTU_FL_CAP_LOW = 5;
    localparam int GTU_FL_CAPTURE_RELOAD_REGISTER = 6;

    // prescaler base shift: 4 cycles first module, 2 cycles second
    localparam int GTU_BASE_FIRST = 2;
    localparam int GTU_BASE_SECOND = 1;

    // pin vector positions
    localparam int GTU_P_LOW_IN = 0;
    localparam int GTU_P_LOW_DIR = 1;
    localparam int GTU_P_C1_IN = 2;
    localparam int GTU_P_C1_DIR = 3;
    localparam int GTU_P_AUX2_IN = 4;
    localparam int GTU_P_C2_IN = 5;
    localparam int GTU_P_C2_DIR = 6;
    localparam int GTU_P_CAPTURE_INPUT_PIN = 7;
    localparam int GTU_NPIN = 8;

    localparam int GTU_CNT_PIN [GTU_NTIM] = '{0, 2, 0, 4, 5};
    localparam int GTU_DIR_PIN [GTU_NTIM] = '{1, 3, 0, 0, 6};
    localparam logic [4:0] GTU_HAS_CNT = 5'h1b;
    localparam logic [4:0] GTU_HAS_DIR = 5'h13;

    localparam logic [15:0] GTU_RST16 = 16'h0000;
    localparam logic [15:0] GTU_MAX16 = 16'hffff;

    typedef enum logic [1:0] {
        GTU_TIMER = 2'b00,
        GTU_GATED = 2'b01,
        GTU_COUNTER = 2'b11,
        GTU_INCR = 2'b10
    } gtu_mode_t;

    typedef struct packed {
        logic [4:0][15:0] ctrl;
        logic [4:0][15:0] cnt;
        logic [15:0] capture_reload_register;
        logic [6:0] flags;
        logic tl1;
        logic tl1_old;
        logic tl2;
        logic tl2_old;
        logic out1;
        logic out2;
        logic ccclk;
        logic [15:0] pre;
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] filt;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } gtu_state_t;

endpackage

// ===== design/gtu_timer_unit.sv
// general purpose timer unit: two modules, five 16-bit timers, apb regs
// assumes pins are asynchronous; apb master on the same clock
//
// What this block does
// - five 16-bit timers in two modules
// - chaining only inside one module
// - first module modes: timer, gated, counter, incremental
// - timer mode counts prescaled system clock
// - counter mode counts selected input pin edges
// - gated mode counts only while gate active
// - first module fastest rate every 4 cycles
// - first module direction by software or pin
// - incremental mode tracks quadrature sensor position
// - core one toggles latch on over/underflow
// - low aux as capture/reload stops counting
// - capture core one into low aux
// - reload core one from low aux
// - high aux has internal sources only
// - second module fastest rate every 2 cycles
// - second module prescaled or external clocking
// - second module direction by software or pin
// - core two toggles its latch on wrap
// - core two wrap clocks array, reloads capture
// - capture_input_pin edge captures aux two, optional clear
// - capture also from core one inputs
// - aux two has no direction pin
`timescale 1ns/1ps

module gtu_timer_unit
    import gtu_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins of the first module
    input wire logic aux_low_count_gate_input,
    input wire logic aux_low_direction_input,
    input wire logic first_core_count_input,
    input wire logic first_core_direction_input,
    // pins of the second module
    input wire logic aux_second_count_gate_input,
    input wire logic second_core_count_input,
    input wire logic second_core_direction_input,
    input wire logic capture_input_pin,
    // outputs
    output logic first_toggle_output_pin,
    output logic second_toggle_output_pin,
    output logic capture_compare_clock
);

    gtu_state_t st_q;
    gtu_state_t st_d;
    logic [7:0] pins;

    assign pins = {capture_input_pin, second_core_direction_input,
        second_core_count_input, aux_second_count_gate_input,
        first_core_direction_input, first_core_count_input,
        aux_low_direction_input, aux_low_count_gate_input};

    function automatic logic edge_hit(input logic [1:0] sel,
        input logic prev, input logic cur);
        edge_hit = (sel[0] & ~prev & cur) | (sel[1] & prev & ~cur);
    endfunction

    function automatic logic pre_tick(input logic [15:0] pre,
        input logic [2:0] ps, input int base);
        logic [15:0] mask;
        mask = 16'((32'h1 << (base + int'(ps))) - 1);
        pre_tick = (pre & mask) == mask;
    endfunction

    always_comb
    begin
        logic [7:0] fnew;
        logic [7:0] rise;
        logic [7:0] fall;
        logic [4:0] ev;
        logic [4:0] dn;
        logic [4:0] ovf;
        logic [6:0] set;
        logic [6:0] clr;
        logic tick;
        logic gate;
        logic srcp;
        logic srcn;
        logic a;
        logic b;
        logic qa;
        logic qb;
        logic [1:0] esel;
        logic [15:0] ci;
        logic rel_ev;
        logic cap_ev;
        logic wr;
        logic rd;
        logic [7:0] idx;
        gtu_mode_t md;
        fnew = 8'h00;
        rise = 8'h00;
        fall = 8'h00;
        tick = 1'b0;
        gate = 1'b0;
        srcp = 1'b0;
        srcn = 1'b0;
        a = 1'b0;
        b = 1'b0;
        qa = 1'b0;
        qb = 1'b0;
        esel = 2'b00;
        ci = 16'h0000;
        rel_ev = 1'b0;
        cap_ev = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        md = GTU_TIMER;
        st_d = st_q;
        set = 7'h00;
        clr = 7'h00;
        ev = 5'h00;
        dn = 5'h00;
        ovf = 5'h00;
        // three stage sync, change taken when stages two and three agree
        st_d.s1 = pins;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        fnew = st_q.filt;
        for (int p = 0; p < GTU_NPIN; p++)
        begin
            if (st_q.s2[p] == st_q.s3[p])
                fnew[p] = st_q.s2[p];
        end
        st_d.filt = fnew;
        rise = fnew & ~st_q.filt;
        fall = ~fnew & st_q.filt;
        st_d.pre = st_q.pre + 16'h0001;
        st_d.tl1_old = st_q.tl1;
        st_d.tl2_old = st_q.tl2;
        // count events and direction per timer
        for (int i = 0; i < GTU_NTIM; i++)
        begin
            md = gtu_mode_t'(st_q.ctrl[i][GTU_MODE_LSB +: 2]);
            esel = st_q.ctrl[i][GTU_EDGE_LSB +: 2];
            tick = pre_tick(st_q.pre, st_q.ctrl[i][GTU_PS_LSB +: 3],
                (i < GTU_AUX2) ? GTU_BASE_FIRST : GTU_BASE_SECOND);
            // chained aux timers see the latch of their own module
            if (st_q.ctrl[i][GTU_CHAIN] && i != GTU_CORE1 && i != GTU_CORE2)
            begin
                srcp = (i == GTU_AUX2) ? st_q.tl2_old : st_q.tl1_old;
                srcn = (i == GTU_AUX2) ? st_q.tl2 : st_q.tl1;
            end
            else if (GTU_HAS_CNT[i])
            begin
                srcp = st_q.filt[GTU_CNT_PIN[i]];
                srcn = fnew[GTU_CNT_PIN[i]];
            end
            else
            begin
                srcp = st_q.tl1_old;
                srcn = st_q.tl1;
            end
            gate = srcn == st_q.ctrl[i][GTU_GATE_LVL];
            dn[i] = st_q.ctrl[i][GTU_DOWN];
            if (GTU_HAS_DIR[i] && st_q.ctrl[i][GTU_EXTDIR])
                dn[i] = dn[i] ^ fnew[GTU_DIR_PIN[i]];
            unique case (md)
                GTU_TIMER: ev[i] = tick;
                GTU_GATED: ev[i] = tick & gate;
                GTU_COUNTER: ev[i] = edge_hit(esel, srcp, srcn);
                GTU_INCR:
                begin
                    // quadrature on count and direction pins
                    if (i == GTU_AUX_LOW || i == GTU_CORE1)
                    begin
                        a = fnew[GTU_CNT_PIN[i]];
                        b = fnew[GTU_DIR_PIN[i]];
                        qa = rise[GTU_CNT_PIN[i]] | fall[GTU_CNT_PIN[i]];
                        qb = rise[GTU_DIR_PIN[i]] | fall[GTU_DIR_PIN[i]];
                        ev[i] = (qa & esel[0]) | (qb & esel[1]);
                        dn[i] = qa ? (a == b) : (a != b);
                        dn[i] = dn[i] ^ st_q.ctrl[i][GTU_DOWN];
                    end
                    else
                        ev[i] = 1'b0;
                end
            endcase
            ev[i] = ev[i] & st_q.ctrl[i][GTU_RUN];
        end
        // low aux used as capture or reload register is stopped
        if (st_q.ctrl[GTU_AUX_LOW][GTU_CR_EN])
            ev[GTU_AUX_LOW] = 1'b0;
        // advance, wrap modulo 2^16 and flag
        for (int i = 0; i < GTU_NTIM; i++)
        begin
            ci = st_q.cnt[i];
            ovf[i] = ev[i] & (dn[i] ? (ci == GTU_RST16) : (ci == GTU_MAX16));
            if (ev[i])
                st_d.cnt[i] = dn[i] ? ci - 16'h0001 : ci + 16'h0001;
            set[i] = ovf[i];
        end
        if (ovf[GTU_CORE1])
            st_d.tl1 = ~st_q.tl1;
        if (ovf[GTU_CORE2])
        begin
            st_d.tl2 = ~st_q.tl2;
            if (st_q.ctrl[GTU_CORE2][GTU_CAPTURE_RELOAD_REGISTER_REL])
                st_d.cnt[GTU_CORE2] = st_q.capture_reload_register;
        end
        st_d.ccclk = ovf[GTU_CORE2];
        // capture / reload with the low aux timer
        esel = st_q.ctrl[GTU_AUX_LOW][GTU_EDGE_LSB +: 2];
        if (st_q.ctrl[GTU_AUX_LOW][GTU_CR_EN])
        begin
            if (!st_q.ctrl[GTU_AUX_LOW][GTU_CR_RELOAD])
            begin
                if (edge_hit(esel, st_q.filt[GTU_P_LOW_IN],
                    fnew[GTU_P_LOW_IN]))
                begin
                    st_d.cnt[GTU_AUX_LOW] = st_q.cnt[GTU_CORE1];
                    set[GTU_FL_CAP_LOW] = 1'b1;
                end
            end
            else
            begin
                if (st_q.ctrl[GTU_AUX_LOW][GTU_REL_LATCH])
                    rel_ev = edge_hit(esel, st_q.tl1_old, st_q.tl1);
                else
                    rel_ev = edge_hit(esel, st_q.filt[GTU_P_LOW_IN],
                        fnew[GTU_P_LOW_IN]);
                if (rel_ev)
                    st_d.cnt[GTU_CORE1] = st_q.cnt[GTU_AUX_LOW];
            end
        end
        // capture of aux two into the capture/reload register
        cap_ev = edge_hit(st_q.ctrl[GTU_CORE2][GTU_CAPEDGE_LSB +: 2],
            st_q.filt[GTU_P_CAPTURE_INPUT_PIN], fnew[GTU_P_CAPTURE_INPUT_PIN]);
        if (st_q.ctrl[GTU_AUX2][GTU_CAP_FIRST_CORE_COUNT_INPUT])
            cap_ev = cap_ev | rise[GTU_P_C1_IN] | fall[GTU_P_C1_IN];
        if (st_q.ctrl[GTU_AUX2][GTU_CAP_T3DIR])
            cap_ev = cap_ev | rise[GTU_P_C1_DIR] | fall[GTU_P_C1_DIR];
        if (cap_ev)
        begin
            st_d.capture_reload_register = st_q.cnt[GTU_AUX2];
            set[GTU_FL_CAPTURE_RELOAD_REGISTER] = 1'b1;
            if (st_q.ctrl[GTU_AUX2][GTU_CAP_CLR])
                st_d.cnt[GTU_AUX2] = GTU_RST16;
        end
        // apb: data sampled one cycle into access, write on pready edge
        rd = psel & penable & ~st_q.pready;
        wr = psel & penable & st_q.pready & pwrite;
        st_d.pready = rd;
        // error flag stands only beside the ready pulse
        st_d.pslverr = 1'b0;
        idx = 8'h00;
        if (rd)
        begin
            st_d.pslverr = 1'b0;
            st_d.prdata = 32'h0000_0000;
            if (paddr[1:0] != 2'b00)
                st_d.pslverr = 1'b1;
            else if (paddr < GTU_CNT_BASE)
            begin
                idx = (paddr - GTU_CTRL_BASE) >> 2;
                st_d.prdata = {16'h0000, st_q.ctrl[idx[2:0]]};
            end
            else if (paddr < GTU_CAPTURE_RELOAD_REGISTER_OFS)
            begin
                idx = (paddr - GTU_CNT_BASE) >> 2;
                st_d.prdata = {16'h0000, st_q.cnt[idx[2:0]]};
            end
            else if (paddr == GTU_CAPTURE_RELOAD_REGISTER_OFS)
                st_d.prdata = {16'h0000, st_q.capture_reload_register};
            else if (paddr == GTU_FLAGS_OFS)
                st_d.prdata = {25'h0000000, st_q.flags};
            else if (paddr == GTU_STATUS_OFS)
                st_d.prdata = {22'h000000, st_q.tl2, st_q.tl1, st_q.filt};
            else
                st_d.pslverr = 1'b1;
        end
        if (wr && !st_q.pslverr)
        begin
            if (paddr < GTU_CNT_BASE)
            begin
                idx = (paddr - GTU_CTRL_BASE) >> 2;
                st_d.ctrl[idx[2:0]] = pwdata[15:0];
            end
            else if (paddr < GTU_CAPTURE_RELOAD_REGISTER_OFS)
            begin
                idx = (paddr - GTU_CNT_BASE) >> 2;
                st_d.cnt[idx[2:0]] = pwdata[15:0];
            end
            else if (paddr == GTU_CAPTURE_RELOAD_REGISTER_OFS)
                st_d.capture_reload_register = pwdata[15:0];
            else if (paddr == GTU_FLAGS_OFS)
                clr = pwdata[6:0];
        end
        // hardware set wins over software clear
        st_d.flags = (st_q.flags & ~clr) | set;
        st_d.out1 = st_d.tl1 & st_q.ctrl[GTU_CORE1][GTU_OUT_EN];
        st_d.out2 = st_d.tl2 & st_q.ctrl[GTU_CORE2][GTU_OUT_EN];
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign first_toggle_output_pin = st_q.out1;
    assign second_toggle_output_pin = st_q.out2;
    assign capture_compare_clock = st_q.ccclk;

endmodule // gtu_timer_unit

// ===== tb/gtu_chk_properties.sv
// apb and output timing checks of the general timer unit
// assumes binding to gtu_timer_unit with its one clock domain
`timescale 1ns/1ps

module gtu_chk
    import gtu_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // outputs
    input wire logic capture_compare_clock,
    input wire logic second_toggle_output_pin
);
    logic acc;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    assign acc = psel && penable && !pready;

    AST_ONE_WAIT: assert property (acc |=> pready)
        else $error("ready not one cycle after access");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_NO_SPURIOUS: assert property (!(psel && penable) |=> !pready)
        else $error("ready without access");
    AST_ERR_QUAL: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_MISALIGNED: assert property (acc && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned access not refused");
    AST_UNMAPPED: assert property (acc && paddr > GTU_STATUS_OFS
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_MAPPED_OK: assert property (acc && paddr[1:0] == 2'h0
        && paddr <= GTU_STATUS_OFS |=> !pslverr)
        else $error("mapped access refused");
    AST_WORD16: assert property (pready && !pwrite
        |-> prdata[31:16] == 16'h0)
        else $error("upper read bits not zero");
    AST_CCCLK_PULSE: assert property (capture_compare_clock
        |=> !capture_compare_clock)
        else $error("array clock pulse too long");
    AST_OUT2_WRAP: assert property (
        $changed(second_toggle_output_pin)
        |-> capture_compare_clock || $past(pready && pwrite, 2))
        else $error("second toggle pin changed without wrap or write");

    cover property (acc ##1 pslverr);
    cover property (pready && pwrite);
    cover property (capture_compare_clock);
endmodule // gtu_chk

bind gtu_timer_unit gtu_chk chk_i (.clock, .reset, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .capture_compare_clock,
    .second_toggle_output_pin);

// ===== tb/gtu_pin_model.sv
// port pins and position sensor lines seen by the timer unit
// assumes the bench asks for a level change by a one-cycle flip strobe
`timescale 1ns/1ps

module gtu_pin_model (
    // clock
    input wire logic clock,
    // change requests
    input wire logic [7:0] flip,
    // pin levels
    output logic [7:0] pins
);
    initial pins = 8'h00;

    always @(posedge clock)
        pins <= pins ^ flip;
endmodule // gtu_pin_model

// ===== tb/tb.sv
// self-checking bench of the general timer unit over apb
// assumes the pin model drives all eight pin inputs
`timescale 1ns/1ps

module tb
    import gtu_pkg::*;
;
    logic clock, reset, psel, penable, pwrite, e;
    logic [7:0] paddr, flip, pins;
    logic [31:0] pwdata, prdata, r;
    logic pready, pslverr, out1, out2, ccclk;
    int failures, checked, ccnt;

    gtu_pin_model model (.clock(clock), .flip(flip), .pins(pins));

    gtu_timer_unit uut (.clock(clock), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr),
        .aux_low_count_gate_input(pins[GTU_P_LOW_IN]),
        .aux_low_direction_input(pins[GTU_P_LOW_DIR]),
        .first_core_count_input(pins[GTU_P_C1_IN]),
        .first_core_direction_input(pins[GTU_P_C1_DIR]),
        .aux_second_count_gate_input(pins[GTU_P_AUX2_IN]),
        .second_core_count_input(pins[GTU_P_C2_IN]),
        .second_core_direction_input(pins[GTU_P_C2_DIR]),
        .capture_input_pin(pins[GTU_P_CAPTURE_INPUT_PIN]),
        .first_toggle_output_pin(out1), .second_toggle_output_pin(out2),
        .capture_compare_clock(ccclk));

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock)
        if (ccclk === 1'b1)
            ccnt++;

    task conclude;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] lo,
        input logic [31:0] hi);
        checked++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, got, lo);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
        begin
            failures++;
            conclude;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r, x, x);
        chk({31'h0, e}, 32'h0, 32'h0);
    endtask

    task tog(input int i);
        flip[i] <= 1'b1;
        @(posedge clock);
        flip[i] <= 1'b0;
        repeat (8) @(posedge clock);
    endtask

    function automatic logic [7:0] ca(input int i);
        return GTU_CTRL_BASE + 8'(4 * i);
    endfunction

    function automatic logic [7:0] na(input int i);
        return GTU_CNT_BASE + 8'(4 * i);
    endfunction

    initial
    begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        flip = 8'h00;
        failures = 0;
        checked = 0;
        ccnt = 0;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        rd(ca(1), 32'h0);
        rd(GTU_FLAGS_OFS, 32'h0);
        apb(1'b0, 8'h34, 32'h0);
        chk({r[30:0], e}, 32'h1, 32'h1);
        apb(1'b0, 8'h02, 32'h0);
        chk({r[30:0], e}, 32'h1, 32'h1);
        wr(ca(1), 32'h20);
        repeat (400) @(posedge clock);
        wr(ca(1), 32'h0);
        apb(1'b0, na(1), 32'h0);
        chk(r, 32'd98, 32'd103);
        wr(ca(4), 32'h20);
        repeat (400) @(posedge clock);
        wr(ca(4), 32'h0);
        apb(1'b0, na(4), 32'h0);
        chk(r, 32'd198, 32'd205);
        tog(GTU_P_C1_DIR);
        wr(na(1), 32'h5);
        wr(ca(1), 32'h8a0);
        repeat (40) @(posedge clock);
        wr(ca(1), 32'h880);
        tog(GTU_P_C1_DIR);
        apb(1'b0, na(1), 32'h0);
        chk(r, 32'hfff6, 32'hffff);
        rd(GTU_STATUS_OFS, 32'h100);
        chk({31'h0, out1}, 32'h1, 32'h1);
        rd(GTU_FLAGS_OFS, 32'h2);
        wr(GTU_FLAGS_OFS, 32'h7f);
        rd(GTU_FLAGS_OFS, 32'h0);
        wr(ca(0), 32'h138);
        repeat (6) tog(GTU_P_LOW_IN);
        rd(na(0), 32'h3);
        wr(ca(0), 32'h428);
        repeat (100) @(posedge clock);
        rd(na(0), 32'h3);
        tog(GTU_P_LOW_IN);
        repeat (100) @(posedge clock);
        tog(GTU_P_LOW_IN);
        wr(ca(0), 32'h0);
        apb(1'b0, na(0), 32'h0);
        chk(r, 32'd28, 32'd33);
        wr(na(1), 32'h0);
        wr(ca(1), 32'h330);
        tog(GTU_P_C1_IN);
        tog(GTU_P_C1_DIR);
        rd(na(1), 32'h2);
        repeat (2) tog(GTU_P_C1_IN);
        tog(GTU_P_C1_DIR);
        rd(na(1), 32'h1);
        wr(ca(1), 32'h0);
        wr(na(1), 32'h1234);
        wr(ca(0), 32'h1120);
        repeat (2) tog(GTU_P_LOW_IN);
        rd(na(0), 32'h1234);
        rd(GTU_FLAGS_OFS, 32'h20);
        wr(na(0), 32'h0abc);
        wr(ca(0), 32'h3120);
        repeat (2) tog(GTU_P_LOW_IN);
        rd(na(1), 32'h0abc);
        wr(ca(0), 32'h0);
        wr(GTU_FLAGS_OFS, 32'h7f);
        wr(na(3), 32'h77);
        wr(ca(3), 32'h1000);
        wr(ca(4), 32'h4000);
        repeat (2) tog(GTU_P_CAPTURE_INPUT_PIN);
        rd(GTU_CAPTURE_RELOAD_REGISTER_OFS, 32'h77);
        rd(na(3), 32'h0);
        rd(GTU_FLAGS_OFS, 32'h40);
        wr(na(3), 32'h55);
        wr(ca(3), 32'h2000);
        wr(ca(4), 32'h0);
        repeat (2) tog(GTU_P_C1_IN);
        rd(GTU_CAPTURE_RELOAD_REGISTER_OFS, 32'h55);
        wr(ca(2), 32'h4338);
        wr(ca(3), 32'h4338);
        wr(na(1), 32'hffff);
        wr(ca(1), 32'h20);
        repeat (10) @(posedge clock);
        wr(ca(1), 32'h0);
        rd(na(2), 32'h1);
        rd(na(3), 32'h55);
        tog(GTU_P_C2_DIR);
        wr(na(4), 32'h10);
        wr(na(3), 32'h0);
        wr(ca(3), 32'ha0);
        wr(ca(4), 32'ha0);
        repeat (20) @(posedge clock);
        wr(ca(4), 32'h0);
        wr(ca(3), 32'h4338);
        tog(GTU_P_C2_DIR);
        apb(1'b0, na(4), 32'h0);
        chk(r, 32'h3, 32'h5);
        apb(1'b0, na(3), 32'h0);
        chk(r, 32'he, 32'h12);
        wr(na(3), 32'h0);
        wr(na(4), 32'hfffc);
        wr(ca(4), 32'h1820);
        repeat (20) @(posedge clock);
        wr(ca(4), 32'h800);
        chk(ccnt, 32'h1, 32'h1);
        chk({31'h0, out2}, 32'h1, 32'h1);
        apb(1'b0, na(4), 32'h0);
        chk(r, 32'h55, 32'h60);
        rd(na(3), 32'h1);
        reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        rd(na(4), 32'h0);
        chk({31'h0, out2}, 32'h0, 32'h0);
        conclude;
    end
endmodule // tb
